/* File: core/pwm_pkg.sv */
// package for the three-phase pwm generator
// assumes one 200 MHz system clock; peripheral rate is half of it
package pwm_pkg;
   // register indices on the data memory bus
   localparam logic [3:0] REG_PERIOD   = 4'h0;
   localparam logic [3:0] REG_DEADTIME = 4'h1;
   localparam logic [3:0] REG_MINPULSE = 4'h2;
   localparam logic [3:0] REG_GATE     = 4'h3;
   localparam logic [3:0] REG_DUTY_A   = 4'h4;
   localparam logic [3:0] REG_DUTY_B   = 4'h5;
   localparam logic [3:0] REG_DUTY_C   = 4'h6;
   localparam logic [3:0] REG_SEGMENT  = 4'h7;
   localparam logic [3:0] REG_STATUS   = 4'h8;
   // widths
   localparam int CNT_W  = 12;
   localparam int CHOP_W = 6;
   // segment fields
   localparam int SEG_XA = 8;
   localparam int SEG_XB = 7;
   localparam int SEG_XC = 6;
   // disable bit positions, one per pin
   localparam int DIS_CL = 0;
   localparam int DIS_CH = 1;
   localparam int DIS_BH = 2;
   localparam int DIS_BL = 3;
   localparam int DIS_AH = 4;
   localparam int DIS_AL = 5;
   // gate fields
   localparam int GATE_HI_EN = 8;
   localparam int GATE_LO_EN = 9;
   // status fields
   localparam int STAT_TRIP = 0;
   localparam int STAT_POL  = 2;
   // reset values
   localparam logic [11:0] PERIOD_RST = 12'h000;
   localparam logic [8:0]  SEG_RST    = 9'h000;
   // sync pulse length in system clocks
   localparam int SYNC_TICKS = 1;
   // timing unit states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_TRIP = 3'b100
   } pwm_state_type;
endpackage

/* File: core/pwm_chopper.sv */
// gate drive carrier: toggles every (chop_divider+1) peripheral ticks
// assumes tick_in is a one-cycle enable at half the clock rate
module pwm_chopper #(
   parameter int W = 6
) (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         srst_in,
   // control
   input  wire logic         tick_in,
   input  wire logic [W-1:0] div_in,
   // carrier
   output logic              carrier_out
);
   logic [W-1:0] cnt_ff;
   logic         car_ff;
   wire          wrap = (cnt_ff >= div_in);

   // half period count, frequency = f_tick / (2*(div+1))
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         cnt_ff <= '0;
         car_ff <= 1'b0;
      end else if (tick_in) begin
         cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
         if (wrap) car_ff <= ~car_ff;
      end
   end
   assign carrier_out = car_ff;
endmodule

/* File: core/three_phase_pwm_generator.sv */
// three-phase center-based pwm generator with output control and gate drive
// assumes single-cycle data memory bus strobes on mclk_in; pins asynchronous
//
// Functional notes
// - logic advances on a peripheral tick at half the system clock
// - registers sit on the data bus, one-cycle read or write
// - six edges derived from three duty values per cycle
// - high and low of a phase never both active
// - on time is duty minus deadtime, centered in the period
// - no deadtime across the cycle boundary
// - sync pulse at each cycle start, to pin, adc and interrupt
// - 12-bit period register sets ticks per cycle
// - pulses shorter than minimum are removed, outputs saturate
// - segment bits 8,7,6 cross over phases a,b,c
// - segment bits 0 to 5 force single pins inactive
// - bit 2 is b high, bit 5 a low, bits 0-1 phase c
// - segment writes take effect at next cycle start
// - segment resets to zero: transparent mode
// - new duties apply only after all three are written
// - output active level follows polarity pin
// - gate bit 8 chops high side outputs with carrier
// - low trip input shuts the controller down
// - chop rate is tick over 2*(value+1); bit 9 chops low side
// - trip disables outputs, raises trip event, status bit 0 shows pin
// - low polarity pin gives active-low outputs; status bit 2 shows it
module three_phase_pwm_generator #(
   parameter int CW = 12
) (
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          srst_in,
   // data memory bus
   input  wire logic          bus_sel_in,
   input  wire logic          bus_wr_in,
   input  wire logic [3:0]    bus_addr_in,
   input  wire logic [15:0]   bus_wdata_in,
   output logic      [15:0]   bus_rdata_out,
   // pins from outside
   input  wire logic          fault_shutdown_n_in,
   input  wire logic          output_polarity_in,
   // inverter outputs
   output logic               phase_a_high_out,
   output logic               phase_a_low_out,
   output logic               phase_b_high_out,
   output logic               phase_b_low_out,
   output logic               phase_c_high_out,
   output logic               phase_c_low_out,
   // cycle start and events
   output logic               cycle_start_pulse_out,
   output logic               adc_start_out,
   output logic               sync_irq_out,
   output logic               trip_irq_out
);
   // =========================================================
   // pin synchronisers
   logic [1:0] trip_sync_ff;
   logic [1:0] pol_sync_ff;
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         trip_sync_ff <= 2'b11;
         pol_sync_ff  <= 2'b00;
      end else begin
         trip_sync_ff <= {trip_sync_ff[0], fault_shutdown_n_in};
         pol_sync_ff  <= {pol_sync_ff[0], output_polarity_in};
      end
   end
   wire trip_lvl_n = trip_sync_ff[1];
   wire pol_lvl    = pol_sync_ff[1];

   // =========================================================
   // peripheral tick, half the system clock
   logic tick_ff;
   always_ff @(posedge mclk_in) begin
      if (srst_in) tick_ff <= 1'b0;
      else         tick_ff <= ~tick_ff;
   end
   wire tick = tick_ff;

   // =========================================================
   // registers
   logic [CW-1:0] period_value_ff;
   logic [CW-1:0] deadtime_value_ff;
   logic [CW-1:0] min_pulse_value_ff;
   logic [9:0]    gate_chop_control_ff;
   logic [CW-1:0] duty_a_ff, duty_b_ff, duty_c_ff;
   logic [CW-1:0] act_a_ff, act_b_ff, act_c_ff;
   logic [2:0]    duty_wr_ff;
   logic [8:0]    segment_control_ff;
   logic [8:0]    seg_act_ff;
   logic          period_loaded_ff;
   logic          trip_evt_ff;

   wire wr = bus_sel_in & bus_wr_in;
   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = wr && (a == r);
   endfunction
   wire wr_per  = hit(bus_addr_in, pwm_pkg::REG_PERIOD);
   wire wr_dt   = hit(bus_addr_in, pwm_pkg::REG_DEADTIME);
   wire wr_pd   = hit(bus_addr_in, pwm_pkg::REG_MINPULSE);
   wire wr_gate = hit(bus_addr_in, pwm_pkg::REG_GATE);
   wire wr_a    = hit(bus_addr_in, pwm_pkg::REG_DUTY_A);
   wire wr_b    = hit(bus_addr_in, pwm_pkg::REG_DUTY_B);
   wire wr_c    = hit(bus_addr_in, pwm_pkg::REG_DUTY_C);
   wire wr_seg  = hit(bus_addr_in, pwm_pkg::REG_SEGMENT);

   // =========================================================
   // timing unit state and counter
   pwm_pkg::pwm_state_type state_ff, nxt_state;
   logic [CW-1:0] cnt_ff;
   wire cyc_end   = tick && (cnt_ff >= period_value_ff - 1'b1);
   wire all_duty  = &duty_wr_ff;
   wire trip_now  = ~trip_lvl_n;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pwm_pkg::ST_IDLE: if (period_loaded_ff && tick)
                              nxt_state = pwm_pkg::ST_RUN;
         pwm_pkg::ST_RUN:  if (trip_now) nxt_state = pwm_pkg::ST_TRIP;
         pwm_pkg::ST_TRIP: if (!trip_now && wr_per)
                              nxt_state = pwm_pkg::ST_IDLE;
         default:          nxt_state = pwm_pkg::ST_IDLE;
      endcase
   end
   wire running = (state_ff == pwm_pkg::ST_RUN);
   wire start   = (state_ff == pwm_pkg::ST_IDLE) && (nxt_state
                  == pwm_pkg::ST_RUN);
   wire cyc_start = start || (running && cyc_end && !trip_now);

   // register writes, cycle reload and state
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_ff             <= pwm_pkg::ST_IDLE;
         cnt_ff               <= '0;
         period_value_ff      <= pwm_pkg::PERIOD_RST;
         deadtime_value_ff    <= '0;
         min_pulse_value_ff   <= '0;
         gate_chop_control_ff <= '0;
         duty_a_ff            <= '0;
         duty_b_ff            <= '0;
         duty_c_ff            <= '0;
         act_a_ff             <= '0;
         act_b_ff             <= '0;
         act_c_ff             <= '0;
         duty_wr_ff           <= '0;
         segment_control_ff   <= pwm_pkg::SEG_RST;
         seg_act_ff           <= pwm_pkg::SEG_RST;
         period_loaded_ff     <= 1'b0;
         trip_evt_ff          <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         trip_evt_ff <= running && trip_now;
         if (wr_per) begin
            period_value_ff  <= bus_wdata_in[CW-1:0];
            period_loaded_ff <= 1'b1;
         end else if (running && trip_now) begin
            period_loaded_ff <= 1'b0; // full reinit needed
         end
         if (wr_dt)   deadtime_value_ff    <= bus_wdata_in[CW-1:0];
         if (wr_pd)   min_pulse_value_ff   <= bus_wdata_in[CW-1:0];
         if (wr_gate) gate_chop_control_ff <= bus_wdata_in[9:0];
         if (wr_a)    duty_a_ff            <= bus_wdata_in[CW-1:0];
         if (wr_b)    duty_b_ff            <= bus_wdata_in[CW-1:0];
         if (wr_c)    duty_c_ff            <= bus_wdata_in[CW-1:0];
         if (wr_seg)  segment_control_ff   <= bus_wdata_in[8:0];
         // set wins over the reload clear
         duty_wr_ff <= (cyc_start && all_duty ? 3'b000 : duty_wr_ff)
                       | {wr_c, wr_b, wr_a};
         if (cyc_start) begin
            cnt_ff     <= '0;
            seg_act_ff <= segment_control_ff;
            if (all_duty) begin
               act_a_ff <= duty_a_ff;
               act_b_ff <= duty_b_ff;
               act_c_ff <= duty_c_ff;
            end
         end else if (running && tick) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   // =========================================================
   // edge calculation, symmetric about the cycle center
   // returns {high, low} raw signals for one phase
   function automatic logic [1:0] phase_raw(
      input logic [CW-1:0] duty, input logic [CW-1:0] dt,
      input logic [CW-1:0] pd,   input logic [CW-1:0] per,
      input logic [CW-1:0] t);
      logic [CW:0] on_w, lo_w, hi_s, hi_e, lo_s, lo_e, tt;
      begin
         on_w = (duty > dt) ? {1'b0, duty - dt} : '0;
         lo_w = ({1'b0, per} > {1'b0, duty} + {1'b0, dt})
                ? {1'b0, per} - {1'b0, duty} - {1'b0, dt} : '0;
         hi_s = ({1'b0, per} - on_w) >> 1;
         hi_e = hi_s + on_w;
         lo_s = lo_w >> 1;
         lo_e = {1'b0, per} - (lo_w >> 1);
         tt   = {1'b0, t};
         if (on_w < {1'b0, pd})
            phase_raw = 2'b01;
         else if (lo_w < {1'b0, pd})
            phase_raw = 2'b10;
         else
            phase_raw = {(tt >= hi_s) && (tt < hi_e),
                         (tt < lo_s) || (tt >= lo_e)};
      end
   endfunction

   wire [1:0] raw_a = phase_raw(act_a_ff, deadtime_value_ff,
                      min_pulse_value_ff, period_value_ff, cnt_ff);
   wire [1:0] raw_b = phase_raw(act_b_ff, deadtime_value_ff,
                      min_pulse_value_ff, period_value_ff, cnt_ff);
   wire [1:0] raw_c = phase_raw(act_c_ff, deadtime_value_ff,
                      min_pulse_value_ff, period_value_ff, cnt_ff);

   // =========================================================
   // output control: crossover then disables
   wire [1:0] xa = seg_act_ff[pwm_pkg::SEG_XA] ? {raw_a[0], raw_a[1]}
                                                : raw_a;
   wire [1:0] xb = seg_act_ff[pwm_pkg::SEG_XB] ? {raw_b[0], raw_b[1]}
                                                : raw_b;
   wire [1:0] xc = seg_act_ff[pwm_pkg::SEG_XC] ? {raw_c[0], raw_c[1]}
                                                : raw_c;
   // active-high "on" per pin, gated by run state and disables
   wire ah_on = running & xa[1] & ~seg_act_ff[pwm_pkg::DIS_AH];
   wire al_on = running & xa[0] & ~seg_act_ff[pwm_pkg::DIS_AL];
   wire bh_on = running & xb[1] & ~seg_act_ff[pwm_pkg::DIS_BH];
   wire bl_on = running & xb[0] & ~seg_act_ff[pwm_pkg::DIS_BL];
   wire ch_on = running & xc[1] & ~seg_act_ff[pwm_pkg::DIS_CH];
   wire cl_on = running & xc[0] & ~seg_act_ff[pwm_pkg::DIS_CL];

   // =========================================================
   // gate drive: chopping and polarity
   logic carrier;
   pwm_chopper #(.W(pwm_pkg::CHOP_W)) u_chop (
      .mclk_in     (mclk_in),
      .srst_in     (srst_in),
      .tick_in     (tick),
      .div_in      (gate_chop_control_ff[pwm_pkg::CHOP_W-1:0]),
      .carrier_out (carrier)
   );
   wire ch_hi = ~gate_chop_control_ff[pwm_pkg::GATE_HI_EN] | carrier;
   wire ch_lo = ~gate_chop_control_ff[pwm_pkg::GATE_LO_EN] | carrier;
   wire [5:0] on_vec = {ah_on & ch_hi, al_on & ch_lo, bh_on & ch_hi,
                        bl_on & ch_lo, ch_on & ch_hi, cl_on & ch_lo};
   // low polarity pin means active-low: invert when pol is 0
   wire [5:0] pin_vec = pol_lvl ? on_vec : ~on_vec;

   logic [5:0] pins_ff;
   logic       sync_ff;
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         pins_ff <= 6'h3F;
         sync_ff <= 1'b0;
      end else begin
         pins_ff <= pin_vec;
         sync_ff <= cyc_start;
      end
   end
   assign {phase_a_high_out, phase_a_low_out, phase_b_high_out,
           phase_b_low_out, phase_c_high_out, phase_c_low_out} = pins_ff;
   assign cycle_start_pulse_out = sync_ff;
   assign adc_start_out         = sync_ff;
   assign sync_irq_out          = sync_ff;
   assign trip_irq_out          = trip_evt_ff;

   // =========================================================
   // read mux
   logic [15:0] rd;
   always_comb begin
      rd = 16'h0000;
      case (bus_addr_in)
         pwm_pkg::REG_PERIOD:   rd[CW-1:0] = period_value_ff;
         pwm_pkg::REG_DEADTIME: rd[CW-1:0] = deadtime_value_ff;
         pwm_pkg::REG_MINPULSE: rd[CW-1:0] = min_pulse_value_ff;
         pwm_pkg::REG_GATE:     rd[9:0]    = gate_chop_control_ff;
         pwm_pkg::REG_DUTY_A:   rd[CW-1:0] = duty_a_ff;
         pwm_pkg::REG_DUTY_B:   rd[CW-1:0] = duty_b_ff;
         pwm_pkg::REG_DUTY_C:   rd[CW-1:0] = duty_c_ff;
         pwm_pkg::REG_SEGMENT:  rd[8:0]    = segment_control_ff;
         pwm_pkg::REG_STATUS: begin
            rd[pwm_pkg::STAT_TRIP] = trip_lvl_n;
            rd[pwm_pkg::STAT_POL]  = pol_lvl;
         end
         default:               rd = 16'h0000;
      endcase
   end
   logic [15:0] rdata_ff;
   always_ff @(posedge mclk_in) begin
      if (srst_in) rdata_ff <= 16'h0000;
      else         rdata_ff <= rd;
   end
   assign bus_rdata_out = rdata_ff;

   // =========================================================
   // assertions
   property p_complement;
      @(posedge mclk_in) disable iff (srst_in)
      running && !seg_act_ff[pwm_pkg::SEG_XA] |-> !(raw_a[1] && raw_a[0]);
   endproperty
   a_complement: assert property (p_complement)
      else $error("phase a high and low both on");

   property p_sync;
      @(posedge mclk_in) disable iff (srst_in)
      cyc_start |=> cycle_start_pulse_out ##1 !cycle_start_pulse_out;
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync pulse not one cycle after start");

   property p_seg_hold;
      @(posedge mclk_in) disable iff (srst_in)
      !cyc_start |=> $stable(seg_act_ff);
   endproperty
   a_seg_hold: assert property (p_seg_hold)
      else $error("segment changed mid cycle");

   // leave the run state, then all pins show the off level
   sequence s_trip_off;
      !running ##1 (pins_ff == {6{~pol_lvl}});
   endsequence
   property p_trip;
      @(posedge mclk_in) disable iff (srst_in)
      running && trip_now |=> s_trip_off;
   endproperty
   a_trip: assert property (p_trip)
      else $error("trip did not shut outputs");

   property p_tick;
      @(posedge mclk_in) disable iff (srst_in)
      tick |=> !tick;
   endproperty
   a_tick: assert property (p_tick)
      else $error("tick not at half rate");

   property p_trip_irq;
      @(posedge mclk_in) disable iff (srst_in)
      running && trip_now |=> trip_irq_out;
   endproperty
   a_trip_irq: assert property (p_trip_irq)
      else $error("trip event missing");

   property p_duty_hold;
      @(posedge mclk_in) disable iff (srst_in)
      !(cyc_start && all_duty) |=> $stable(act_a_ff);
   endproperty
   a_duty_hold: assert property (p_duty_hold)
      else $error("duty applied before all three written");

   property p_disable;
      @(posedge mclk_in) disable iff (srst_in)
      seg_act_ff[pwm_pkg::DIS_AL] |=> phase_a_low_out == ~pol_lvl;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disabled pin went active");
endmodule

/* File: sim/inverter_gate_model.sv */
// gate drive and inverter stand-in for the three-phase pwm generator
// assumes the six gate pins in order ah,al,bh,bl,ch,cl on gate_in[0..5]
module inverter_gate_model (
   // clock and reset
   input  wire logic              mclk_in,
   input  wire logic              srst_in,
   // strapping and fault command from the bench
   input  wire logic              pol_level_in,
   input  wire logic              fault_cmd_in,
   // pins from the generator
   input  wire logic [5:0]        gate_in,
   input  wire logic              sync_in,
   input  wire logic              adc_in,
   input  wire logic              irq_in,
   // pins back to the generator
   output logic                   polarity_pin_out,
   output logic                   fault_n_out,
   // measurements of the last whole cycle
   output logic [5:0][15:0]       on_clk_out,
   output logic [15:0]            cycle_clk_out,
   output logic [15:0]            overlap_out,
   output logic [15:0]            event_err_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // strapping
   logic [5:0]       act;
   logic             both_on;
   logic [5:0][15:0] acc;
   logic [15:0]      len;
   logic [15:0]      ovl;
   // gate circuit fixes the active level by hardware
   assign polarity_pin_out = pol_level_in;
   assign fault_n_out = ~fault_cmd_in;
   assign act = gate_in ~^ {6{pol_level_in}};
   assign both_on = (act[0] & act[1]) | (act[2] & act[3]) | (act[4] & act[5]);
   // ==========================================================
   // measurement between two cycle-start pulses; pins lag the pulse
   // by one clock, so the sample taken with the pulse closes the window
   always @(posedge mclk_in) begin
      if (srst_in) begin
         on_clk_out <= '0;
         cycle_clk_out <= '0;
         overlap_out <= '0;
         event_err_out <= '0;
         acc <= '0;
         len <= '0;
         ovl <= '0;
      end else begin
         if (adc_in !== sync_in || irq_in !== sync_in) begin
            event_err_out <= event_err_out + 16'h0001;
         end
         if (sync_in === 1'b1) begin
            for (int i = 0; i < 6; i++) begin
               on_clk_out[i] <= acc[i] + {15'h0000, act[i]};
            end
            cycle_clk_out <= len + 16'h0001;
            overlap_out <= ovl + {15'h0000, both_on};
            acc <= '0;
            len <= 16'h0000;
            ovl <= 16'h0000;
         end else begin
            for (int i = 0; i < 6; i++) begin
               acc[i] <= acc[i] + {15'h0000, act[i]};
            end
            len <= len + 16'h0001;
            ovl <= ovl + {15'h0000, both_on};
         end
      end
   end
endmodule

/* File: sim/three_phase_pwm_generator_tb_top.sv */
// self-checking bench for the three-phase pwm generator
// assumes 200 MHz mclk_in and the inverter model on the gate pins
module three_phase_pwm_generator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [11:0] per, dt, pd, da, db, dc;
      logic [8:0]  seg;
      logic        pol;
   } row_type;
   logic             mclk_in, srst_in, bus_sel, bus_wr, pol_level, fault_cmd;
   logic [3:0]       bus_addr;
   logic [15:0]      bus_wdata, rdata, rd, cyc_len, ovl, ev_err;
   logic             fault_n, pol_pin, sync, adc, irq, trip_irq;
   logic [5:0]       gate;
   logic [5:0][15:0] on_clk, e;
   row_type          r;
   int               n_errors, checks_done, cycles;
   // rows other than the narrow-pulse one keep duty in the safe range
   row_type rows [5] = '{'{20, 1, 0, 9, 11, 5, 9'h000, 1},
      '{20, 1, 0, 9, 11, 5, 9'h1C0, 1}, '{20, 1, 0, 9, 11, 5, 9'h0A7, 1},
      '{16, 2, 5, 6, 8, 13, 9'h000, 1}, '{20, 1, 0, 9, 11, 5, 9'h000, 0}};
   // ==========================================================
   // design and far side
   three_phase_pwm_generator DUT (.mclk_in(mclk_in), .srst_in(srst_in),
      .bus_sel_in(bus_sel), .bus_wr_in(bus_wr), .bus_addr_in(bus_addr),
      .bus_wdata_in(bus_wdata), .bus_rdata_out(rdata),
      .fault_shutdown_n_in(fault_n), .output_polarity_in(pol_pin),
      .phase_a_high_out(gate[0]), .phase_a_low_out(gate[1]),
      .phase_b_high_out(gate[2]), .phase_b_low_out(gate[3]),
      .phase_c_high_out(gate[4]), .phase_c_low_out(gate[5]),
      .cycle_start_pulse_out(sync), .adc_start_out(adc),
      .sync_irq_out(irq), .trip_irq_out(trip_irq));
   inverter_gate_model model (.mclk_in(mclk_in), .srst_in(srst_in),
      .pol_level_in(pol_level), .fault_cmd_in(fault_cmd), .gate_in(gate),
      .sync_in(sync), .adc_in(adc), .irq_in(irq),
      .polarity_pin_out(pol_pin), .fault_n_out(fault_n),
      .on_clk_out(on_clk), .cycle_clk_out(cyc_len), .overlap_out(ovl),
      .event_err_out(ev_err));
   // ==========================================================
   // clock and watchdog
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ==========================================================
   // helpers
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
      @(negedge mclk_in);
      bus_sel = 1'b1;
      bus_wr = 1'b1;
      bus_addr = a;
      bus_wdata = d;
      @(negedge mclk_in);
      bus_sel = 1'b0;
      bus_wr = 1'b0;
   endtask
   task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
      @(negedge mclk_in);
      bus_sel = 1'b1;
      bus_addr = a;
      @(negedge mclk_in);
      d = rdata;
      bus_sel = 1'b0;
   endtask
   task automatic wait_sync(input int n);
      repeat (n) @(posedge mclk_in iff sync === 1'b1);
      @(negedge mclk_in);
   endtask
   task automatic apply(input row_type x);
      pol_level = x.pol;
      bus_write(pwm_pkg::REG_PERIOD, {4'h0, x.per});
      bus_write(pwm_pkg::REG_DEADTIME, {4'h0, x.dt});
      bus_write(pwm_pkg::REG_MINPULSE, {4'h0, x.pd});
      bus_write(pwm_pkg::REG_DUTY_A, {4'h0, x.da});
      bus_write(pwm_pkg::REG_DUTY_B, {4'h0, x.db});
      bus_write(pwm_pkg::REG_DUTY_C, {4'h0, x.dc});
      bus_write(pwm_pkg::REG_SEGMENT, {7'h00, x.seg});
   endtask
   // active clocks per pin in one cycle, worked out from the settings
   function automatic logic [5:0][15:0] expect_counts(input row_type x);
      logic [2:0][11:0] d;
      logic [15:0]      hi, lo, t;
      logic [5:0][15:0] q;
      int               xb[3], hb[3], lb[3];
      d = {x.dc, x.db, x.da};
      xb = '{pwm_pkg::SEG_XA, pwm_pkg::SEG_XB, pwm_pkg::SEG_XC};
      hb = '{pwm_pkg::DIS_AH, pwm_pkg::DIS_BH, pwm_pkg::DIS_CH};
      lb = '{pwm_pkg::DIS_AL, pwm_pkg::DIS_BL, pwm_pkg::DIS_CL};
      for (int p = 0; p < 3; p++) begin
         hi = {4'h0, d[p]} - {4'h0, x.dt};
         lo = {4'h0, x.per} - {4'h0, d[p]} - {4'h0, x.dt};
         if (hi < {4'h0, x.pd}) begin
            hi = 16'h0000;
            lo = {4'h0, x.per};
         end else if (lo < {4'h0, x.pd}) begin
            hi = {4'h0, x.per};
            lo = 16'h0000;
         end
         if (x.seg[xb[p]]) begin
            t = hi;
            hi = lo;
            lo = t;
         end
         q[2*p] = x.seg[hb[p]] ? 16'h0000 : hi << 1;
         q[2*p+1] = x.seg[lb[p]] ? 16'h0000 : lo << 1;
      end
      return q;
   endfunction
   task automatic check_counts(input row_type x);
      e = expect_counts(x);
      for (int i = 0; i < 6; i++)
         chk(on_clk[i], e[i]);
      chk(cyc_len, {3'h0, x.per, 1'b0});
      chk(ovl, 16'h0000);
      chk(ev_err, 16'h0000);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      srst_in = 1'b1;
      bus_sel = 1'b0;
      bus_wr = 1'b0;
      bus_addr = 4'h0;
      bus_wdata = 16'h0000;
      pol_level = 1'b1;
      fault_cmd = 1'b0;
      repeat (12) @(negedge mclk_in);
      srst_in = 1'b0;
      // reset values, status and an unmapped index
      bus_read(pwm_pkg::REG_PERIOD, rd);
      chk(rd, 16'h0000);
      bus_read(pwm_pkg::REG_SEGMENT, rd);
      chk(rd, 16'h0000);
      bus_read(4'hF, rd);
      chk(rd, 16'h0000);
      bus_read(pwm_pkg::REG_STATUS, rd);
      chk(rd & 16'h0005, 16'h0005);
      bus_write(pwm_pkg::REG_DEADTIME, 16'h0ABC);
      bus_read(pwm_pkg::REG_DEADTIME, rd);
      chk(rd, 16'h0ABC);
      // table of steady-state settings
      foreach (rows[i]) begin
         apply(rows[i]);
         wait_sync(3);
         check_counts(rows[i]);
      end
      // segment write in mid-cycle waits for the next cycle start
      r = rows[0];
      apply(r);
      wait_sync(3);
      bus_write(pwm_pkg::REG_SEGMENT, 16'h003F);
      wait_sync(1);
      check_counts(r);
      r.seg = 9'h03F;
      wait_sync(1);
      check_counts(r);
      // duties only move once all three are written
      r = rows[0];
      bus_write(pwm_pkg::REG_SEGMENT, 16'h0000);
      bus_write(pwm_pkg::REG_DUTY_A, 16'h000B);
      bus_write(pwm_pkg::REG_DUTY_B, 16'h0009);
      wait_sync(3);
      check_counts(r);
      bus_write(pwm_pkg::REG_DUTY_C, 16'h0005);
      r.da = 12'h00B;
      r.db = 12'h009;
      wait_sync(3);
      check_counts(r);
      // gate chopping on high side, then on low side
      e = expect_counts(r);
      bus_write(pwm_pkg::REG_GATE, 16'h0100);
      wait_sync(3);
      chk({15'h0000, on_clk[0] < e[0] && on_clk[0] > 0}, 16'h0001);
      chk(on_clk[1], e[1]);
      bus_write(pwm_pkg::REG_GATE, 16'h0200);
      wait_sync(3);
      chk({15'h0000, on_clk[3] < e[3] && on_clk[3] > 0}, 16'h0001);
      chk(on_clk[2], e[2]);
      bus_write(pwm_pkg::REG_GATE, 16'h0000);
      // fault pin shuts everything off until a fresh start
      fault_cmd = 1'b1;
      for (int k = 0; k < 20 && trip_irq !== 1'b1; k++) @(negedge mclk_in);
      chk({15'h0000, trip_irq}, 16'h0001);
      repeat (8) @(negedge mclk_in);
      chk({10'h000, gate}, 16'h0000);
      bus_read(pwm_pkg::REG_STATUS, rd);
      chk(rd & 16'h0005, 16'h0004);
      fault_cmd = 1'b0;
      repeat (8) @(negedge mclk_in);
      chk({10'h000, gate}, 16'h0000);
      apply(rows[0]);
      wait_sync(3);
      check_counts(rows[0]);
      // reset in mid-run returns to the unloaded, transparent state
      srst_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      srst_in = 1'b0;
      bus_read(pwm_pkg::REG_PERIOD, rd);
      chk(rd, 16'h0000);
      bus_read(pwm_pkg::REG_SEGMENT, rd);
      chk(rd, 16'h0000);
      end_of_test();
   end
endmodule
